// File: bench/tb.sv
// Testbench for the T1 line code unit with the far end looped back.
// Assumes short bit and flash counts; exact pipeline lags are searched in a narrow range.
`timescale 1ns/100ps
module tb;
  import tlc_pkg::*;
  localparam int BITC = 4;
  localparam int FLASH = 16;
  logic CLK_IN = 1'b0;
  logic RESET_IN = 1'b1;
  logic LINE_B8ZS_IN = 1'b0;
  logic FORMAT_ESF_IN = 1'b0;
  logic TX_DATA_IN = 1'b1;
  logic YEL_SF_IN = 1'b0;
  logic YEL_ESF_IN = 1'b0;
  logic inject = 1'b0;
  logic TX_TAKE_OUT, TX_POS_OUT, TX_NEG_OUT, RX_DATA_OUT, RX_VALID_OUT, BPV_OUT, AIS_OUT, ALARM_LED_OUT;
  tlc_sym_t tx_sym;
  tlc_sym_t rx_sym;
  bit src_q[$];
  logic [1:0] sent_log[$];
  logic [1:0] sym_log[$];
  logic [1:0] rx_log[$];
  int bpv_cnt = 0;
  int error_cnt = 0;
  int checked = 0;
  assign tx_sym = {TX_POS_OUT, TX_NEG_OUT};
  always #10 CLK_IN = !CLK_IN;
  tlc_line_unit #(.BIT_CYCLES(BITC), .FLASH_CYCLES(FLASH)) DUT (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .LINE_B8ZS_IN(LINE_B8ZS_IN), .FORMAT_ESF_IN(FORMAT_ESF_IN),
    .TX_DATA_IN(TX_DATA_IN), .TX_TAKE_OUT(TX_TAKE_OUT), .TX_POS_OUT(TX_POS_OUT), .TX_NEG_OUT(TX_NEG_OUT),
    .RX_POS_IN(rx_sym.pos), .RX_NEG_IN(rx_sym.neg), .RX_DATA_OUT(RX_DATA_OUT), .RX_VALID_OUT(RX_VALID_OUT),
    .BPV_OUT(BPV_OUT), .YEL_SF_IN(YEL_SF_IN), .YEL_ESF_IN(YEL_ESF_IN), .AIS_OUT(AIS_OUT),
    .ALARM_LED_OUT(ALARM_LED_OUT));
  tlc_far_end far (.clk_in(CLK_IN), .take_in(TX_TAKE_OUT), .inject_in(inject), .line_in(tx_sym),
    .line_out(rx_sym));
  // ==========================================================
  // Feeding and logging; idle data is all ones
  always @(posedge CLK_IN) begin
    if (TX_TAKE_OUT) begin
      sent_log.push_back({1'b0, TX_DATA_IN});
      sym_log.push_back(tx_sym);
      TX_DATA_IN <= (src_q.size() > 0) ? src_q.pop_front() : 1'b1;
    end
    if (RX_VALID_OUT) rx_log.push_back({1'b0, RX_DATA_OUT});
    if (BPV_OUT) bpv_cnt++;
  end
  // ==========================================================
  // Helpers
  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  function automatic logic [1:0] mk(input bit p);
    return p ? 2'b10 : 2'b01;
  endfunction
  // Reference encoder, polarity reference negative after reset
  function automatic void encode(input bit b8, input logic [1:0] b[$], output logic [1:0] s[$]);
    bit p;
    bit z;
    int i;
    p = 1'b0;
    i = 0;
    s = {};
    while (i < b.size()) begin
      z = b8 && (i + 8 <= b.size());
      for (int k = 0; k < 8; k++) if (z && b[i + k] !== 2'b00) z = 1'b0;
      if (z) begin
        s = {s, 2'b00, 2'b00, 2'b00, mk(p), mk(!p), 2'b00, mk(!p), mk(p)};
        i += 8;
      end else begin
        if (b[i] === 2'b01) p = !p;
        s.push_back((b[i] === 2'b01) ? mk(p) : 2'b00);
        i++;
      end
    end
  endfunction
  // Pipeline depth fixed but only known to within a few bits
  function automatic bit lag_match(input logic [1:0] e[$], input logic [1:0] g[$], input int lo, input int hi);
    bit ok;
    for (int l = lo; l <= hi; l++) begin
      ok = 1'b1;
      for (int i = 0; i < e.size() - 40; i++) if (i + l >= g.size() || g[i + l] !== e[i]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic do_reset(input bit b8);
    RESET_IN <= 1'b1;
    LINE_B8ZS_IN <= b8;
    repeat (10) @(posedge CLK_IN);
    sent_log = {};
    sym_log = {};
    rx_log = {};
    bpv_cnt = 0;
    RESET_IN <= 1'b0;
  endtask
  task automatic run_stream(input bit b8, input string s);
    logic [1:0] e[$];
    do_reset(b8);
    foreach (s[k]) src_q.push_back(s[k] == "1");
    repeat ((s.len() + 40) * BITC) @(posedge CLK_IN);
    encode(b8, sent_log, e);
    check(lag_match(e, sym_log, 7, 10), "line symbols");
    check(lag_match(sent_log, rx_log, 14, 20), "recovered data");
    check(bpv_cnt == 0, "violation on clean line");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_ami();
    // Dense ones except one long run that must stay idle
    run_stream(1'b0, "110100101100000000010111001011011101101011");
    $display("test ami done");
  endtask
  task automatic t_b8zs();
    run_stream(1'b1, "1000000001100000000000000001000000000000100000000101000000001");
    $display("test b8zs done");
  endtask
  task automatic t_bpv();
    do_reset(1'b0);
    repeat (12) src_q.push_back(1'b1);
    repeat (10) src_q = {src_q, 1'b1, 1'b0, 1'b0, 1'b0};
    repeat (30 * BITC) @(posedge CLK_IN);
    inject <= 1'b1;
    @(posedge CLK_IN);
    inject <= 1'b0;
    repeat (40 * BITC) @(posedge CLK_IN);
    check(bpv_cnt == 1, "one inserted violation");
    $display("test bpv done");
  endtask
  task automatic count_led(input int cyc, output int n);
    logic prev;
    n = 0;
    // Settle first, so a change launched at the calling edge is not counted
    #1;
    prev = ALARM_LED_OUT;
    repeat (cyc) begin
      @(posedge CLK_IN);
      #1;
      if (ALARM_LED_OUT !== prev) n++;
      prev = ALARM_LED_OUT;
    end
  endtask
  task automatic t_alarm();
    int n;
    do_reset(1'b0);
    FORMAT_ESF_IN <= 1'b0;
    YEL_SF_IN <= 1'b1;
    repeat (4) @(posedge CLK_IN);
    count_led(8 * FLASH, n);
    check(n >= 7 && n <= 8 && AIS_OUT === 1'b0, "flash on superframe yellow");
    FORMAT_ESF_IN <= 1'b1;
    repeat (4) @(posedge CLK_IN);
    count_led(4 * FLASH, n);
    check(n == 0 && ALARM_LED_OUT === 1'b0, "other format yellow ignored");
    YEL_ESF_IN <= 1'b1;
    repeat (4) @(posedge CLK_IN);
    count_led(8 * FLASH, n);
    check(n >= 7 && n <= 8, "flash on extended yellow");
    repeat ((2 * 2048 + 60) * BITC) @(posedge CLK_IN);
    count_led(4 * FLASH, n);
    check(AIS_OUT === 1'b1 && n == 0 && ALARM_LED_OUT === 1'b1, "steady on blue code");
    YEL_ESF_IN <= 1'b0;
    $display("test alarm done");
  endtask
  // ==========================================================
  // Run control
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge CLK_IN);
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    t_ami();
    t_b8zs();
    t_bpv();
    t_alarm();
    end_sim();
  end
endmodule

// File: bench/tlc_far_end.sv
// Far-end T1 equipment: loops our transmit line back onto our receive pins.
// Assumes symbols hold a whole bit period; one pulse can be inserted on request.
`timescale 1ns/100ps
module tlc_far_end (
  input wire logic clk_in,
  input wire logic take_in,
  input wire logic inject_in,
  input wire tlc_pkg::tlc_sym_t line_in,
  output tlc_pkg::tlc_sym_t line_out
);
  import tlc_pkg::*;
  // ==========================================================
  // Line loopback
  logic arm_ff = 1'b0;
  logic last_pos_ff = 1'b0;
  logic idle;
  assign idle = !line_in.pos && !line_in.neg;
  // Marks pass unchanged, so alternation seen is our own
  always_comb begin
    line_out = line_in;
    if (arm_ff && idle) begin
      // Same polarity as last mark, a deliberate violation
      line_out.pos = last_pos_ff;
      line_out.neg = !last_pos_ff;
    end
  end
  // Armed until one whole idle slot has carried the extra pulse
  always_ff @(posedge clk_in) begin
    if (!idle) last_pos_ff <= line_in.pos;
    if (inject_in) arm_ff <= 1'b1;
    else if (take_in && arm_ff && idle) arm_ff <= 1'b0;
  end
endmodule

// File: rtl/tlc_line_unit.sv
// T1 line code unit: AMI / zero-substitution encoder, decoder and alarm indication.
// Assumes one 50 MHz clock; receive symbols arrive aligned to the internal bit rate.
// Contract
// - Each one bit goes out as a line pulse; each zero leaves the line idle.
// - Successive marks alternate polarity so the receiver can spot coding errors.
// - In substitution mode eight zeros become a pattern holding two polarity violations.
// - In substitution mode the receiver restores the eight zeros exactly.
// - Framing is extended superframe or superframe, matching the far end.
// - Same-polarity marks outside a valid pattern raise a violation indication.
// - Yellow alarm flashes the indicator; received all-ones blue code holds it steady.
`timescale 1ns/100ps
`include "tlc_defs.svh"
module tlc_line_unit #(
  parameter int BIT_CYCLES = `TLC_BIT_CYCLES,
  parameter int FLASH_CYCLES = `TLC_FLASH_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic LINE_B8ZS_IN,
  input wire logic FORMAT_ESF_IN,
  input wire logic TX_DATA_IN,
  output logic TX_TAKE_OUT,
  output logic TX_POS_OUT,
  output logic TX_NEG_OUT,
  input wire logic RX_POS_IN,
  input wire logic RX_NEG_IN,
  output logic RX_DATA_OUT,
  output logic RX_VALID_OUT,
  output logic BPV_OUT,
  input wire logic YEL_SF_IN,
  input wire logic YEL_ESF_IN,
  output logic AIS_OUT,
  output logic ALARM_LED_OUT
);
  import tlc_pkg::*;

  localparam int BW = $clog2(BIT_CYCLES);
  localparam int FW = $clog2(FLASH_CYCLES);
  localparam int AW = $clog2(`TLC_AIS_WINDOW);
  // Literals cannot be indexed, so the pattern masks live here
  localparam logic [7:0] SUB_MARKS = `TLC_SUB_MARKS;
  localparam logic [7:0] SUB_SAME = `TLC_SUB_SAME;

  // ==========================================================
  // Bit rate enable
  logic [BW-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic bit_en_ff, nxt_bit_en;

  always_comb begin
    nxt_bit_en = (bit_cnt_ff == BW'(BIT_CYCLES - 1));
    nxt_bit_cnt = nxt_bit_en ? '0 : bit_cnt_ff + 1'b1;
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      bit_cnt_ff <= '0;
      bit_en_ff <= 1'b0;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      bit_en_ff <= nxt_bit_en;
    end
  end

  assign TX_TAKE_OUT = bit_en_ff;

  // ==========================================================
  // Transmit encoder, eight bits of look-ahead for zero runs
  tlc_tx_state_t state_ff, nxt_state;
  logic [7:0] sr_ff, nxt_sr;
  logic [3:0] sub_cnt_ff, nxt_sub_cnt;
  logic [2:0] step;
  logic last_pol_ff, nxt_last_pol, sub_pol_ff, nxt_sub_pol;
  logic tx_pos_ff, nxt_tx_pos, tx_neg_ff, nxt_tx_neg;
  logic mark, mark_pos, pol_after;

  always_comb begin
    nxt_state = state_ff;
    nxt_sr = sr_ff;
    nxt_sub_cnt = sub_cnt_ff;
    nxt_last_pol = last_pol_ff;
    nxt_sub_pol = sub_pol_ff;
    nxt_tx_pos = tx_pos_ff;
    nxt_tx_neg = tx_neg_ff;
    step = 3'(`TLC_SUB_LEN - sub_cnt_ff);
    mark = 1'b0;
    mark_pos = 1'b0;
    pol_after = last_pol_ff;
    if (bit_en_ff) begin
      case (state_ff)
        TLC_TX_SUB: begin
          mark = SUB_MARKS[step];
          mark_pos = SUB_SAME[step] ? sub_pol_ff : !sub_pol_ff;
        end
        default: begin
          mark = sr_ff[0];
          mark_pos = !last_pol_ff;
        end
      endcase
      nxt_tx_pos = mark & mark_pos;
      nxt_tx_neg = mark & !mark_pos;
      if (mark) begin
        pol_after = mark_pos;
      end
      nxt_last_pol = pol_after;
      nxt_sr = {TX_DATA_IN, sr_ff[7:1]};
      nxt_sub_cnt = (state_ff == TLC_TX_SUB) ? sub_cnt_ff - 4'h1 : 4'h0;
      nxt_state = (nxt_sub_cnt != 4'h0) ? TLC_TX_SUB : TLC_TX_PASS;
      // Plain AMI relies on the far end for ones density
      if (LINE_B8ZS_IN && nxt_sub_cnt == 4'h0 && nxt_sr == 8'h00) begin
        nxt_sub_cnt = `TLC_SUB_LEN;
        nxt_sub_pol = pol_after;
        nxt_state = TLC_TX_SUB;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_ff <= TLC_TX_PASS;
      sr_ff <= 8'h00;
      sub_cnt_ff <= 4'h0;
      last_pol_ff <= `TLC_POL_RESET;
      sub_pol_ff <= `TLC_POL_RESET;
      tx_pos_ff <= 1'b0;
      tx_neg_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sr_ff <= nxt_sr;
      sub_cnt_ff <= nxt_sub_cnt;
      last_pol_ff <= nxt_last_pol;
      sub_pol_ff <= nxt_sub_pol;
      tx_pos_ff <= nxt_tx_pos;
      tx_neg_ff <= nxt_tx_neg;
    end
  end

  assign TX_POS_OUT = tx_pos_ff;
  assign TX_NEG_OUT = tx_neg_ff;

  // ==========================================================
  // Receive pins: two-stage synchroniser, then decoder
  tlc_sym_t rx_meta_ff, rx_sync_ff;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rx_meta_ff <= '0;
      rx_sync_ff <= '0;
    end else begin
      rx_meta_ff <= '{pos: RX_POS_IN, neg: RX_NEG_IN};
      rx_sync_ff <= rx_meta_ff;
    end
  end

  tlc_rx_decode u_rx_decode (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .bit_en_in(bit_en_ff),
    .b8zs_in(LINE_B8ZS_IN),
    .sym_in(rx_sync_ff),
    .data_out(RX_DATA_OUT),
    .valid_out(RX_VALID_OUT),
    .bpv_out(BPV_OUT)
  );

  // ==========================================================
  // Alarms: blue code over a fixed window, yellow per framing format
  logic [AW-1:0] ais_win_ff, nxt_ais_win;
  logic [1:0] zero_cnt_ff, nxt_zero_cnt, zero_sum;
  logic ais_ff, nxt_ais;
  logic [FW-1:0] flash_cnt_ff, nxt_flash_cnt;
  logic flash_ff, nxt_flash, yellow, led_ff, nxt_led;

  always_comb begin
    nxt_ais_win = ais_win_ff;
    nxt_zero_cnt = zero_cnt_ff;
    nxt_ais = ais_ff;
    zero_sum = (zero_cnt_ff == `TLC_AIS_MAX_ZEROS) ? zero_cnt_ff : zero_cnt_ff + 2'(!RX_DATA_OUT);
    if (RX_VALID_OUT) begin
      nxt_ais_win = ais_win_ff + 1'b1;
      nxt_zero_cnt = zero_sum;
      if (ais_win_ff == AW'(`TLC_AIS_WINDOW - 1)) begin
        nxt_ais = (zero_sum < `TLC_AIS_MAX_ZEROS);
        nxt_zero_cnt = 2'h0;
      end
    end
    // Yellow is taken from the framer of the configured format only
    yellow = FORMAT_ESF_IN ? YEL_ESF_IN : YEL_SF_IN;
    nxt_flash_cnt = (flash_cnt_ff == FW'(FLASH_CYCLES - 1)) ? '0 : flash_cnt_ff + 1'b1;
    nxt_flash = (flash_cnt_ff == FW'(FLASH_CYCLES - 1)) ? !flash_ff : flash_ff;
    nxt_led = ais_ff | (yellow & flash_ff);
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ais_win_ff <= '0;
      zero_cnt_ff <= 2'h0;
      ais_ff <= 1'b0;
      flash_cnt_ff <= '0;
      flash_ff <= 1'b0;
      led_ff <= 1'b0;
    end else begin
      ais_win_ff <= nxt_ais_win;
      zero_cnt_ff <= nxt_zero_cnt;
      ais_ff <= nxt_ais;
      flash_cnt_ff <= nxt_flash_cnt;
      flash_ff <= nxt_flash;
      led_ff <= nxt_led;
    end
  end

  assign AIS_OUT = ais_ff;
  assign ALARM_LED_OUT = led_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  chk_space_idle: assert property (bit_en_ff && state_ff == TLC_TX_PASS && !sr_ff[0]
    |=> !TX_POS_OUT && !TX_NEG_OUT)
    else $error("zero bit produced a pulse");
  chk_mark_pulse: assert property (bit_en_ff && state_ff == TLC_TX_PASS && sr_ff[0]
    |=> TX_POS_OUT ^ TX_NEG_OUT)
    else $error("one bit produced no single pulse");
  chk_ami_alternate: assert property (bit_en_ff && state_ff == TLC_TX_PASS && sr_ff[0]
    |=> TX_POS_OUT == !$past(last_pol_ff))
    else $error("mark polarity did not alternate");
  chk_sub_start: assert property (bit_en_ff && LINE_B8ZS_IN && state_ff == TLC_TX_PASS
    && sr_ff[7:1] == 7'h00 && !TX_DATA_IN |=> state_ff == TLC_TX_SUB && sub_cnt_ff == 4'h8)
    else $error("eight zero run not substituted");
  chk_sub_violation: assert property (bit_en_ff && state_ff == TLC_TX_SUB && step == 3'h3
    |=> TX_POS_OUT == sub_pol_ff && TX_NEG_OUT == !sub_pol_ff)
    else $error("first violation of pattern has wrong polarity");
  chk_ami_nosub: assert property (!LINE_B8ZS_IN && state_ff == TLC_TX_PASS |=> state_ff == TLC_TX_PASS)
    else $error("substitution entered in plain AMI mode");
  chk_ais_steady: assert property (ais_ff |=> ALARM_LED_OUT)
    else $error("blue code indicator not steady");
  chk_yellow_format: assert property (!ais_ff && FORMAT_ESF_IN && !YEL_ESF_IN |=> !ALARM_LED_OUT)
    else $error("indicator lit without alarm of configured format");
endmodule

// File: rtl/tlc_rx_decode.sv
// Receive decoder: bipolar symbols to data, zero-substitution removal, violation flag.
// Assumes symbols already synchronised and one symbol per bit enable.
`timescale 1ns/100ps
`include "tlc_defs.svh"
module tlc_rx_decode (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic bit_en_in,
  input wire logic b8zs_in,
  input wire tlc_pkg::tlc_sym_t sym_in,
  output logic data_out,
  output logic valid_out,
  output logic bpv_out
);
  import tlc_pkg::*;

  // Literals cannot be indexed, so the pattern masks live here
  localparam logic [7:0] SUB_MARKS = `TLC_SUB_MARKS;
  localparam logic [7:0] SUB_SAME = `TLC_SUB_SAME;

  tlc_sym_t sym_ff [0:7];
  tlc_sym_t nxt_sym [0:7];
  tlc_sym_t win [0:7];
  tlc_sym_t lead;
  logic pol_ff, nxt_pol, pol_now, in_sub;
  logic [3:0] cnt_ff, nxt_cnt;
  logic data_ff, nxt_data, valid_ff, nxt_valid, bpv_ff, nxt_bpv;

  function automatic logic match_sub(input tlc_sym_t w [0:7], input logic pol);
    logic ok;
    logic exp_pos;
    ok = 1'b1;
    for (int j = 0; j < 8; j++) begin
      exp_pos = SUB_SAME[j] ? pol : !pol;
      if (w[j].pos != (SUB_MARKS[j] & exp_pos) || w[j].neg != (SUB_MARKS[j] & !exp_pos)) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ==========================================================
  // Eight-symbol window; the oldest symbol leaves each bit
  always_comb begin
    lead = sym_ff[0];
    in_sub = (cnt_ff != 4'h0);
    pol_now = pol_ff;
    for (int i = 0; i < 7; i++) begin
      win[i] = sym_ff[i + 1];
    end
    win[7] = sym_in;
    nxt_sym = sym_ff;
    nxt_pol = pol_ff;
    nxt_cnt = cnt_ff;
    nxt_data = data_ff;
    nxt_valid = 1'b0;
    nxt_bpv = 1'b0;
    if (bit_en_in) begin
      nxt_valid = 1'b1;
      nxt_data = (lead.pos | lead.neg) & !in_sub;
      // Same polarity twice outside a pattern, or a double pulse
      nxt_bpv = !in_sub & ((lead.pos & lead.neg) | (lead.pos & pol_ff) | (lead.neg & !pol_ff));
      if (lead.pos ^ lead.neg) begin
        pol_now = lead.pos;
      end
      nxt_pol = pol_now;
      nxt_sym = win;
      nxt_cnt = in_sub ? cnt_ff - 4'h1 : 4'h0;
      if (b8zs_in && cnt_ff <= 4'h1 && match_sub(win, pol_now)) begin
        nxt_cnt = `TLC_SUB_LEN;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < 8; i++) begin
        sym_ff[i] <= '0;
      end
      pol_ff <= `TLC_POL_RESET;
      cnt_ff <= 4'h0;
      data_ff <= 1'b0;
      valid_ff <= 1'b0;
      bpv_ff <= 1'b0;
    end else begin
      sym_ff <= nxt_sym;
      pol_ff <= nxt_pol;
      cnt_ff <= nxt_cnt;
      data_ff <= nxt_data;
      valid_ff <= nxt_valid;
      bpv_ff <= nxt_bpv;
    end
  end

  assign data_out = data_ff;
  assign valid_out = valid_ff;
  assign bpv_out = bpv_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_sub_restore: assert property (bit_en_in && in_sub |=> valid_out && !data_out && !bpv_out)
    else $error("substituted slot not restored to zero");
  chk_bpv_flag: assert property (bit_en_in && !in_sub && (lead.pos ^ lead.neg)
    && (lead.pos == pol_ff) |=> bpv_out)
    else $error("repeated mark polarity not flagged");
  chk_bpv_quiet: assert property (bit_en_in && (lead.pos ^ lead.neg) && (lead.pos != pol_ff) |=> !bpv_out)
    else $error("alternating mark flagged as violation");
endmodule

// File: shared/tlc_defs.svh
// Timing counts and fixed line-code patterns for the T1 line code unit.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef TLC_DEFS_SVH
`define TLC_DEFS_SVH
// ==========================================================
// Rates and times
`define TLC_CLK_KHZ 50000
`define TLC_LINE_KHZ 1544
`define TLC_BIT_CYCLES (`TLC_CLK_KHZ / `TLC_LINE_KHZ)
`define TLC_FLASH_HALF_MS 250
`define TLC_FLASH_CYCLES (`TLC_FLASH_HALF_MS * `TLC_CLK_KHZ)
// ==========================================================
// Substitution pattern, bit j is step j of the eight slots
`define TLC_SUB_LEN 4'h8
`define TLC_SUB_MARKS 8'hd8
`define TLC_SUB_SAME 8'h88
// ==========================================================
// Blue code detection
`define TLC_AIS_WINDOW 2048
`define TLC_AIS_MAX_ZEROS 2'h3
// Last mark taken as negative so the first mark goes positive
`define TLC_POL_RESET 1'b0
`endif

// File: shared/tlc_pkg.sv
// Types shared by the T1 line code unit.
// Assumes nothing beyond a SystemVerilog compiler.
package tlc_pkg;
  // ==========================================================
  // One line symbol: both high is an illegal double pulse
  typedef struct packed {
    logic pos;
    logic neg;
  } tlc_sym_t;

  // ==========================================================
  // Transmit encoder states
  typedef enum logic [1:0] {
    TLC_TX_PASS = 2'b01,
    TLC_TX_SUB = 2'b10
  } tlc_tx_state_t;
endpackage
